// [logic/cps_pkg.sv]
/*
  package of the clock path select and output control block: register map, field
  positions, reset values, source and format codes, and the carrier structs.
  assumes a 32-bit axi4-lite register bus with byte addresses and one word per register.
*/
package cps_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_MAIN_CONTROL_ONE = 12'h000;
  localparam logic [11:0] OFS_MAIN_CONTROL_TWO = 12'h004;
  localparam logic [11:0] OFS_GLOBAL_INTERRUPT_STATUS = 12'h008;
  localparam logic [11:0] OFS_INPUT_RECEIVER_ENABLES = 12'h00C;
  localparam logic [11:0] OFS_BANK_PATH_SELECT = 12'h010;
  localparam logic [11:0] OFS_DIVIDER_ENABLE_BITS = 12'h014;
  localparam logic [11:0] OFS_PATH_ONE_CONTROL_ONE = 12'h020;
  localparam logic [11:0] OFS_PATH_ONE_CONTROL_THREE = 12'h024;
  localparam logic [11:0] OFS_PATH_ONE_STATUS = 12'h028;
  localparam logic [11:0] OFS_PATH_STRIDE = 12'h010;
  localparam logic [11:0] OFS_OUTPUT_CONTROL_TWO = 12'h100;
  localparam logic [11:0] OFS_OUTPUT_DIFFERENTIAL_LEVELS = 12'h200;

  // field positions
  localparam int POS_RING_OSC_DISABLE = 0;
  localparam int POS_CRYSTAL_MODE = 0;
  localparam int POS_BOOT_CONFIG_DONE = 0;
  localparam int POS_SWITCH_PIN_CHOICE = 0;
  localparam int POS_PRIMARY_SELECT = 0;
  localparam int POS_ALTERNATE_SELECT = 4;
  localparam int POS_PIN_SWITCH_ENABLE = 8;
  localparam int POS_SELECTED_REFERENCE = 0;
  localparam int POS_SIGNAL_FORMAT = 0;
  localparam int POS_OUTPUT_INVERT = 4;
  localparam int POS_DRIVE = 5;
  localparam int POS_SWING_LEVEL = 0;
  localparam int POS_COMMON_MODE_LEVEL = 4;

  // crystal pin buffer mode codes, and reset values of the crystal mode, swing level and common mode level
  localparam logic [1:0] XMODE_CRYSTAL = 2'h1;
  localparam logic [1:0] XMODE_SINGLE_ENDED = 2'h2;
  localparam logic [1:0] RST_CRYSTAL_MODE = 2'h0;
  localparam logic [3:0] RST_COMMON_MODE_LEVEL = 4'h0;
  localparam logic [3:0] RST_SWING_LEVEL = 4'h0;

  // path input sources
  typedef enum logic [2:0] {
    CPS_SRC_CLK1 = 3'b000,
    CPS_SRC_CLK2 = 3'b001,
    CPS_SRC_CLK3 = 3'b010,
    CPS_SRC_XPIN = 3'b011,
    CPS_SRC_XDRV = 3'b100
  } cps_src_e;

  // output signal format codes
  localparam logic [3:0] FMT_DISABLED = 4'h0;
  localparam logic [3:0] FMT_LVDS = 4'h1;
  localparam logic [3:0] FMT_PROG_DIFF = 4'h2;
  localparam logic [3:0] FMT_HCSL = 4'h3;
  localparam logic [3:0] FMT_HSTL = 4'h4;
  localparam logic [3:0] FMT_SE_NEG_OFF = 4'h5;
  localparam logic [3:0] FMT_SE_NEG_SAME = 4'h6;
  localparam logic [3:0] FMT_SE_NEG_INV = 4'h7;
  localparam logic [3:0] FMT_SE_NEG_DIV = 4'h8;

  // negative pin modes and differential kinds at the driver
  localparam logic [1:0] NEG_OFF = 2'h0;
  localparam logic [1:0] NEG_SAME = 2'h1;
  localparam logic [1:0] NEG_INV = 2'h2;
  localparam logic [1:0] DIFF_NONE = 2'h0;
  localparam logic [1:0] DIFF_LVDS = 2'h1;
  localparam logic [1:0] DIFF_PROG = 2'h2;
  localparam logic [1:0] DIFF_HCSL = 2'h3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // per-path configuration
  typedef struct packed {
    logic pin_switch_enable;
    logic [1:0] switch_pin_choice;
    logic [2:0] primary_select;
    logic [2:0] alternate_input_select;
  } cps_pcfg_s;

  // per-output configuration as software wrote it
  typedef struct packed {
    logic [3:0] output_signal_format;
    logic output_invert;
    logic [1:0] drive;
    logic [3:0] swing_level;
    logic [3:0] common_mode_level;
  } cps_ocfg_s;

  // per-output controls presented to the analog driver and divider chain
  typedef struct packed {
    logic driver_on;
    logic low_power;
    logic div_en;
    logic invert;
    logic [1:0] drive;
    logic [1:0] neg_mode;
    logic neg_div;
    logic [1:0] diff_kind;
    logic [3:0] swing_level;
    logic [3:0] common_mode_level;
  } cps_octl_s;

endpackage : cps_pkg

// [logic/cps_ctl.sv]
/*
  clock path select and output control: axi4-lite register slave, crystal pin mode,
  ring oscillator gating, input receiver enables, two fanout path selectors with
  gpio switching and live status, and per-output driver and divider controls.
  assumes aclk at 250 mhz, gpio pins asynchronous, boot done flag from another clock.
*/
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

module cps_ctl #(
  parameter int NOUT = 10,
  parameter int NBANK = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] gpio_in,
  input wire logic boot_config_done,
  output logic crystal_driver_en,
  output logic crystal_pin_a_input_en,
  output logic ring_osc_en,
  output logic [2:0] input_receiver_en,
  output logic [1:0][2:0] path_source,
  output logic [NBANK-1:0] bank_path_select,
  output cps_pkg::cps_octl_s [NOUT-1:0] output_ctl
);

  typedef struct packed {
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] gpio_s1;
    logic [3:0] gpio_s2;
    logic done_s1;
    logic done_s2;
    logic [1:0] crystal_pin_buffer_mode;
    logic ring_osc_disable;
    logic [2:0] rx_en;
    logic [NBANK-1:0] bank_sel;
    logic [NOUT-1:0] divider_enable_bits;
    cps_pkg::cps_pcfg_s [1:0] pcfg;
    cps_pkg::cps_ocfg_s [NOUT-1:0] ocfg;
    logic xtal_drv;
    logic xtal_in;
    logic rosc_on;
    logic [1:0][2:0] src;
    cps_pkg::cps_octl_s [NOUT-1:0] octl;
  } cps_state_s;

  cps_state_s st;
  cps_state_s next_st;

  // byte-lane merge of a write into the current register word
  function automatic logic [31:0] cps_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : cps_merge

  // register readback; hit reports a mapped address
  function automatic logic [31:0] cps_read(input cps_state_s s, input logic [11:0] a,
                                           output logic hit);
    logic [31:0] d;
    d = 32'h0000_0000;
    hit = 1'b1;
    if (a == cps_pkg::OFS_MAIN_CONTROL_ONE) begin
      d[cps_pkg::POS_RING_OSC_DISABLE] = s.ring_osc_disable;
    end else if (a == cps_pkg::OFS_MAIN_CONTROL_TWO) begin
      d[cps_pkg::POS_CRYSTAL_MODE +: 2] = s.crystal_pin_buffer_mode;
    end else if (a == cps_pkg::OFS_GLOBAL_INTERRUPT_STATUS) begin
      d[cps_pkg::POS_BOOT_CONFIG_DONE] = s.done_s2;
    end else if (a == cps_pkg::OFS_INPUT_RECEIVER_ENABLES) begin
      d[2:0] = s.rx_en;
    end else if (a == cps_pkg::OFS_BANK_PATH_SELECT) begin
      d[NBANK-1:0] = s.bank_sel;
    end else if (a == cps_pkg::OFS_DIVIDER_ENABLE_BITS) begin
      d[NOUT-1:0] = s.divider_enable_bits;
    end else begin
      // paths and outputs decode by stride; a word that matches nothing stays unmapped
      hit = 1'b0;
      for (int p = 0; p < 2; p++) begin
        if (a == cps_pkg::OFS_PATH_ONE_CONTROL_ONE + 12'(p) * cps_pkg::OFS_PATH_STRIDE) begin
          d[cps_pkg::POS_SWITCH_PIN_CHOICE +: 2] = s.pcfg[p].switch_pin_choice;
          hit = 1'b1;
        end
        if (a == cps_pkg::OFS_PATH_ONE_CONTROL_THREE + 12'(p) * cps_pkg::OFS_PATH_STRIDE) begin
          d[cps_pkg::POS_PRIMARY_SELECT +: 3] = s.pcfg[p].primary_select;
          d[cps_pkg::POS_ALTERNATE_SELECT +: 3] = s.pcfg[p].alternate_input_select;
          d[cps_pkg::POS_PIN_SWITCH_ENABLE] = s.pcfg[p].pin_switch_enable;
          hit = 1'b1;
        end
        if (a == cps_pkg::OFS_PATH_ONE_STATUS + 12'(p) * cps_pkg::OFS_PATH_STRIDE) begin
          d[cps_pkg::POS_SELECTED_REFERENCE +: 3] = s.src[p];
          hit = 1'b1;
        end
      end
      for (int i = 0; i < NOUT; i++) begin
        if (a == cps_pkg::OFS_OUTPUT_CONTROL_TWO + 12'(i * 4)) begin
          d[cps_pkg::POS_SIGNAL_FORMAT +: 4] = s.ocfg[i].output_signal_format;
          d[cps_pkg::POS_OUTPUT_INVERT] = s.ocfg[i].output_invert;
          d[cps_pkg::POS_DRIVE +: 2] = s.ocfg[i].drive;
          hit = 1'b1;
        end
        if (a == cps_pkg::OFS_OUTPUT_DIFFERENTIAL_LEVELS + 12'(i * 4)) begin
          d[cps_pkg::POS_SWING_LEVEL +: 4] = s.ocfg[i].swing_level;
          d[cps_pkg::POS_COMMON_MODE_LEVEL +: 4] = s.ocfg[i].common_mode_level;
          hit = 1'b1;
        end
      end
    end
    return d;
  endfunction : cps_read

  always_comb begin
    logic [31:0] old_word;
    logic [31:0] wd;
    logic [31:0] rd_word;
    logic whit;
    logic rhit;
    logic do_write;
    logic pin_level;
    logic [3:0] fmt;
    old_word = 32'h0000_0000;
    wd = 32'h0000_0000;
    rd_word = 32'h0000_0000;
    whit = 1'b0;
    rhit = 1'b0;
    pin_level = 1'b0;
    fmt = 4'h0;
    do_write = 1'b0;
    next_st = st;

    // gpio and boot-done cross in through two flops each
    next_st.gpio_s1 = gpio_in;
    next_st.gpio_s2 = st.gpio_s1;
    next_st.done_s1 = boot_config_done;
    next_st.done_s2 = st.done_s1;

    // write address and data are caught independently, in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // the register file runs on aclk only, never on the ring oscillator
    do_write = st.aw_full && st.w_full && !st.bvalid;
    if (do_write) begin
      old_word = cps_read(st, {st.aw_addr[11:2], 2'b00}, whit);
      wd = cps_merge(old_word, st.w_data, st.w_strb);
      next_st.aw_full = 1'b0;
      next_st.w_full = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = whit ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
      unique case ({st.aw_addr[11:2], 2'b00})
        cps_pkg::OFS_MAIN_CONTROL_ONE: begin
          next_st.ring_osc_disable = wd[cps_pkg::POS_RING_OSC_DISABLE];
        end
        cps_pkg::OFS_MAIN_CONTROL_TWO: begin
          next_st.crystal_pin_buffer_mode = wd[cps_pkg::POS_CRYSTAL_MODE +: 2];
        end
        cps_pkg::OFS_INPUT_RECEIVER_ENABLES: begin
          next_st.rx_en = wd[2:0];
        end
        cps_pkg::OFS_BANK_PATH_SELECT: begin
          next_st.bank_sel = wd[NBANK-1:0];
        end
        cps_pkg::OFS_DIVIDER_ENABLE_BITS: begin
          next_st.divider_enable_bits = wd[NOUT-1:0];
        end
        default: begin
          for (int p = 0; p < 2; p++) begin
            if ({st.aw_addr[11:2], 2'b00} ==
                cps_pkg::OFS_PATH_ONE_CONTROL_ONE + 12'(p) * cps_pkg::OFS_PATH_STRIDE) begin
              next_st.pcfg[p].switch_pin_choice = wd[cps_pkg::POS_SWITCH_PIN_CHOICE +: 2];
            end
            if ({st.aw_addr[11:2], 2'b00} ==
                cps_pkg::OFS_PATH_ONE_CONTROL_THREE + 12'(p) * cps_pkg::OFS_PATH_STRIDE) begin
              next_st.pcfg[p].primary_select = wd[cps_pkg::POS_PRIMARY_SELECT +: 3];
              next_st.pcfg[p].alternate_input_select = wd[cps_pkg::POS_ALTERNATE_SELECT +: 3];
              next_st.pcfg[p].pin_switch_enable = wd[cps_pkg::POS_PIN_SWITCH_ENABLE];
            end
          end
          for (int i = 0; i < NOUT; i++) begin
            if ({st.aw_addr[11:2], 2'b00} == cps_pkg::OFS_OUTPUT_CONTROL_TWO + 12'(i * 4)) begin
              next_st.ocfg[i].output_signal_format = wd[cps_pkg::POS_SIGNAL_FORMAT +: 4];
              next_st.ocfg[i].output_invert = wd[cps_pkg::POS_OUTPUT_INVERT];
              next_st.ocfg[i].drive = wd[cps_pkg::POS_DRIVE +: 2];
            end
            if ({st.aw_addr[11:2], 2'b00} ==
                cps_pkg::OFS_OUTPUT_DIFFERENTIAL_LEVELS + 12'(i * 4)) begin
              next_st.ocfg[i].swing_level = wd[cps_pkg::POS_SWING_LEVEL +: 4];
              next_st.ocfg[i].common_mode_level = wd[cps_pkg::POS_COMMON_MODE_LEVEL +: 4];
            end
          end
        end
      endcase
    end
    // one write in flight: a side stays closed from taking its half until the write response is accepted
    next_st.awready = !next_st.aw_full && !next_st.bvalid;
    next_st.wready = !next_st.w_full && !next_st.bvalid;

    // reads answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      rd_word = cps_read(st, {s_axi_araddr[11:2], 2'b00}, rhit);
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rhit ? cps_pkg::RESP_OKAY : cps_pkg::RESP_SLVERR;
    end
    // arready falls with the address it takes, so a second read waits for rready
    next_st.arready = !next_st.rvalid;

    next_st.xtal_drv = (st.crystal_pin_buffer_mode == cps_pkg::XMODE_CRYSTAL);
    next_st.xtal_in = (st.crystal_pin_buffer_mode == cps_pkg::XMODE_SINGLE_ENDED);
    // disable only counts once boot is seen done, so boot never loses its clock
    next_st.rosc_on = !(st.ring_osc_disable && st.done_s2);

    // status reads this registered choice, so it always matches path_source
    // two identical selectors
    for (int p = 0; p < 2; p++) begin
      pin_level = st.gpio_s2[st.pcfg[p].switch_pin_choice];
      if (st.pcfg[p].pin_switch_enable && pin_level) begin
        next_st.src[p] = st.pcfg[p].alternate_input_select;
      end else begin
        next_st.src[p] = st.pcfg[p].primary_select;
      end
    end

    // codes above 8 keep the driver on but unshaped; software should not use them
    for (int i = 0; i < NOUT; i++) begin
      fmt = st.ocfg[i].output_signal_format;
      next_st.octl[i].driver_on = (fmt != cps_pkg::FMT_DISABLED);
      next_st.octl[i].low_power = (fmt == cps_pkg::FMT_DISABLED);
      next_st.octl[i].div_en = st.divider_enable_bits[i];
      next_st.octl[i].invert = st.ocfg[i].output_invert;
      next_st.octl[i].drive = st.ocfg[i].drive;
      next_st.octl[i].neg_mode = cps_pkg::NEG_OFF;
      next_st.octl[i].neg_div = 1'b0;
      next_st.octl[i].diff_kind = cps_pkg::DIFF_NONE;
      next_st.octl[i].swing_level = 4'h0;
      next_st.octl[i].common_mode_level = 4'h0;
      unique case (fmt)
        cps_pkg::FMT_LVDS: begin
          // swing is fixed by the driver in this format
          next_st.octl[i].diff_kind = cps_pkg::DIFF_LVDS;
          next_st.octl[i].common_mode_level = st.ocfg[i].common_mode_level;
        end
        cps_pkg::FMT_PROG_DIFF: begin
          next_st.octl[i].diff_kind = cps_pkg::DIFF_PROG;
          next_st.octl[i].swing_level = st.ocfg[i].swing_level;
          next_st.octl[i].common_mode_level = st.ocfg[i].common_mode_level;
        end
        cps_pkg::FMT_HCSL: begin
          next_st.octl[i].diff_kind = cps_pkg::DIFF_HCSL;
          next_st.octl[i].swing_level = st.ocfg[i].swing_level;
          next_st.octl[i].common_mode_level = st.ocfg[i].common_mode_level;
        end
        cps_pkg::FMT_HSTL: begin
          next_st.octl[i].neg_mode = cps_pkg::NEG_INV;
        end
        cps_pkg::FMT_SE_NEG_SAME: begin
          next_st.octl[i].neg_mode = cps_pkg::NEG_SAME;
        end
        cps_pkg::FMT_SE_NEG_INV: begin
          next_st.octl[i].neg_mode = cps_pkg::NEG_INV;
        end
        cps_pkg::FMT_SE_NEG_DIV: begin
          next_st.octl[i].neg_mode = cps_pkg::NEG_SAME;
          next_st.octl[i].neg_div = 1'b1;
        end
        default: begin
          // disabled, negative pin off, and undefined codes leave the negative pin off
          next_st.octl[i].neg_mode = cps_pkg::NEG_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // readies stay low here and rise on the first edge after release
      st <= '0;
      st.crystal_pin_buffer_mode <= cps_pkg::RST_CRYSTAL_MODE;
      st.rosc_on <= 1'b1;
      for (int i = 0; i < NOUT; i++) begin
        st.ocfg[i].swing_level <= cps_pkg::RST_SWING_LEVEL;
        st.ocfg[i].common_mode_level <= cps_pkg::RST_COMMON_MODE_LEVEL;
        st.octl[i].low_power <= 1'b1;
      end
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign crystal_driver_en = st.xtal_drv;
  assign crystal_pin_a_input_en = st.xtal_in;
  assign ring_osc_en = st.rosc_on;
  assign input_receiver_en = st.rx_en;
  assign path_source = st.src;
  assign bank_path_select = st.bank_sel;
  assign output_ctl = st.octl;

endmodule : cps_ctl

`default_nettype wire

// [sim/cps_pins_model.sv]
/*
  far-side pin model: gpio switch pins and the boot done flag.
  assumes the bench sets the wanted levels; pins move off the design's clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_pins_model (
  input wire logic aclk,
  input wire logic [3:0] gpio_req,
  input wire logic boot_req,
  output logic [3:0] gpio_in,
  output logic boot_config_done
);
  // pins are asynchronous, so they change on the falling edge, never at sampling
  always_ff @(negedge aclk) begin
    gpio_in <= gpio_req;
    boot_config_done <= boot_req;
  end
endmodule : cps_pins_model
`default_nettype wire

// [sim/cps_ctl_monitor.sv]
/*
  checker of the clock path select block: bus answers, reset state,
  ring oscillator gating and output driver codes.
  assumes it is bound into cps_ctl and sees only that module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_ctl_monitor #(
  parameter int NOUT = 10,
  parameter int NBANK = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic boot_config_done,
  input wire logic ring_osc_en,
  input wire logic crystal_driver_en,
  input wire logic crystal_pin_a_input_en,
  input wire cps_pkg::cps_octl_s [NOUT-1:0] output_ctl
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_osc_on: assert property (disable iff (1'b0)
    !aresetn |=> ring_osc_en && output_ctl[3].low_power)
    else $error("reset left ring oscillator off or driver powered");
  a_xtal_mode_excl: assert property (crystal_driver_en |-> !crystal_pin_a_input_en)
    else $error("crystal driver and pin input both on");
  a_osc_stop_boot: assert property ($fell(ring_osc_en) |-> $past(boot_config_done, 3))
    else $error("ring oscillator stopped before boot done");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready)
    else $error("read not answered next cycle");
  a_no_aw_in_b: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during write response");
  a_off_low_power: assert property (!output_ctl[3].driver_on |-> output_ctl[3].low_power)
    else $error("disabled driver not in low power");
  a_lvds_swing_zero: assert property (output_ctl[3].diff_kind == cps_pkg::DIFF_LVDS |->
    output_ctl[3].swing_level == 4'h0)
    else $error("swing level applied in lvds mode");
  c_osc_off: cover property ($fell(ring_osc_en));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : cps_ctl_monitor
`default_nettype wire
bind cps_ctl cps_ctl_monitor #(.NOUT(NOUT), .NBANK(NBANK)) u_cps_ctl_monitor (.*);

// [sim/cps_ctl_tb_top.sv]
/*
  self-checking bench of cps_ctl: register writes over axi4-lite, field outputs,
  path selection by field and gpio, output driver codes.
  assumes default parameters NOUT=10, NBANK=6 and output 3 as the watched output.
*/
`timescale 1ns/100ps
`default_nettype none
module cps_ctl_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, boot_req = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hf, gpio_req = 4'h0, gpio_in;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic boot_config_done, crystal_driver_en, crystal_pin_a_input_en, ring_osc_en;
  logic [2:0] input_receiver_en;
  logic [1:0][2:0] path_source;
  logic [5:0] bank_path_select;
  cps_pkg::cps_octl_s [9:0] output_ctl;
  cps_pkg::cps_octl_s o;
  int n_fail = 0, n_checks = 0;
  cps_ctl u_cps_ctl (.*);
  cps_pins_model u_cps_pins_model (.*);
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic print_verdict;
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : settle
  // readies are sampled before the edge's updates land, as the slave sees them
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic t_reset_crystal;
    chk(ring_osc_en, 1'b1);
    chk(output_ctl[3].low_power, 1'b1);
    rd(cps_pkg::OFS_MAIN_CONTROL_TWO, v);
    chk(v, cps_pkg::RST_CRYSTAL_MODE);
    for (int m = 0; m < 4; m++) begin
      wr(cps_pkg::OFS_MAIN_CONTROL_TWO, m);
      settle(2);
      chk(crystal_driver_en, m == cps_pkg::XMODE_CRYSTAL);
      chk(crystal_pin_a_input_en, m == cps_pkg::XMODE_SINGLE_ENDED);
    end
  endtask : t_reset_crystal
  task automatic t_ring_osc;
    // disable before boot done must not stop the oscillator yet
    wr(cps_pkg::OFS_MAIN_CONTROL_ONE, 32'h0000_0001);
    settle(6);
    chk(ring_osc_en, 1'b1);
    boot_req = 1'b1;
    settle(5);
    chk(ring_osc_en, 1'b0);
    rd(cps_pkg::OFS_GLOBAL_INTERRUPT_STATUS, v);
    chk(v, 32'h0000_0001);
    rd(12'h0FC, v);
    chk(resp, cps_pkg::RESP_SLVERR);
    chk(v, 32'h0000_0000);
    wr(12'h0FC, 32'h0000_0001);
    chk(resp, cps_pkg::RESP_SLVERR);
  endtask : t_ring_osc
  task automatic t_enables;
    wr(cps_pkg::OFS_INPUT_RECEIVER_ENABLES, 32'h0000_0005);
    wr(cps_pkg::OFS_BANK_PATH_SELECT, 32'h0000_002A);
    settle(2);
    chk(input_receiver_en, 3'h5);
    chk(bank_path_select, 6'h2A);
    wr(cps_pkg::OFS_INPUT_RECEIVER_ENABLES, 32'h0000_0002);
    settle(2);
    chk(input_receiver_en, 3'h2);
    // lane 0 masked: the enable bits must not change
    @(posedge aclk);
    s_axi_wstrb <= 4'he;
    wr(cps_pkg::OFS_INPUT_RECEIVER_ENABLES, 32'h0000_0007);
    s_axi_wstrb <= 4'hf;
    settle(2);
    chk(input_receiver_en, 3'h2);
  endtask : t_enables
  task automatic t_mid_reset;
    // a second reset must restart the stopped oscillator for the boot controller
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    chk(ring_osc_en, 1'b1);
    rd(cps_pkg::OFS_MAIN_CONTROL_ONE, v);
    chk(v, 32'h0000_0000);
  endtask : t_mid_reset
  task automatic t_paths;
    logic [11:0] b;
    for (int p = 0; p < 2; p++) begin
      b = cps_pkg::OFS_PATH_STRIDE * p;
      for (int s = 0; s < 5; s++) begin
        wr(cps_pkg::OFS_PATH_ONE_CONTROL_THREE + b, s);
        settle(2);
        chk(path_source[p], s);
        rd(cps_pkg::OFS_PATH_ONE_STATUS + b, v);
        chk(v, s);
      end
      // other pins high, chosen pin low: selector must stay on primary
      gpio_req = ~(4'h1 << (p + 2));
      wr(cps_pkg::OFS_PATH_ONE_CONTROL_ONE + b, p + 2);
      wr(cps_pkg::OFS_PATH_ONE_CONTROL_THREE + b, 32'h0000_0141);
      settle(5);
      chk(path_source[p], cps_pkg::CPS_SRC_CLK2);
      gpio_req = 4'h1 << (p + 2);
      settle(5);
      chk(path_source[p], cps_pkg::CPS_SRC_XDRV);
      wr(cps_pkg::OFS_PATH_ONE_CONTROL_THREE + b, 32'h0000_0041);
      settle(2);
      chk(path_source[p], cps_pkg::CPS_SRC_CLK2);
    end
  endtask : t_paths
  task automatic t_outputs;
    wr(cps_pkg::OFS_OUTPUT_DIFFERENTIAL_LEVELS + 12'h00C, 32'h0000_0035);
    wr(cps_pkg::OFS_DIVIDER_ENABLE_BITS, 32'h0000_0008);
    for (int k = 0; k < 9; k++) begin
      wr(cps_pkg::OFS_OUTPUT_CONTROL_TWO + 12'h00C, 32'h0000_0050 | k);
      settle(2);
      o = output_ctl[3];
      chk(o.driver_on, k != 0);
      chk(o.low_power, k == 0);
      chk({o.invert, o.drive}, 3'h6);
      chk(o.div_en, 1'b1);
      if (k == 1) chk({o.diff_kind, o.swing_level, o.common_mode_level}, 10'h103);
      if (k == 2) chk({o.diff_kind, o.swing_level, o.common_mode_level}, 10'h253);
      if (k == 3) chk(o.diff_kind, cps_pkg::DIFF_HCSL);
      if (k >= 5 && k <= 7) chk(o.neg_mode, k - 5);
      if (k == 8) chk(o.neg_div, 1'b1);
    end
    wr(cps_pkg::OFS_OUTPUT_CONTROL_TWO + 12'h00C, 32'h0000_0001);
    settle(2);
    chk(output_ctl[3].invert, 1'b0);
    chk(output_ctl[2].div_en, 1'b0);
  endtask : t_outputs
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle(2);
    t_reset_crystal();
    t_ring_osc();
    t_mid_reset();
    t_enables();
    t_paths();
    t_outputs();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    print_verdict();
  end
endmodule : cps_ctl_tb_top
`default_nettype wire
